// ==== bench/backplane_interrupt_unit_monitor.sv ====
// Checker for the backplane interrupt unit, bound to the unit's ports.
// Assumes the single clk domain and the register offsets of the package.
`timescale 1ns/1ps
module backplane_interrupt_unit_monitor
	import backplane_irq_pkg::*;
(
	// Clock, reset and local bus
	input wire logic clk, rst_n, io_wr, io_ready,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata, io_rdata,
	// Host side
	input wire logic [1:0] host_level_strap,
	input wire logic host_channel_check, host_irq5, host_irq11, host_irq12,
	// Backplane side
	input wire logic [7:1] irq_n_i, irq_n_oe,
	input wire logic iack_n, remote_iack_n, vme_data_oe, dtack_n_i, dtack_n_oe,
	input wire logic [2:0] iack_level, remote_iack_level,
	input wire logic [7:0] vme_data_i, vme_data_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Helper: last vector written while no answer or acknowledge runs
	logic wr_out;
	logic [7:0] last_vec;
	assign wr_out = io_wr && io_addr == OFS_OUT_VECTOR;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_vec <= 8'h00;
		end else if (wr_out && iack_n && !vme_data_oe) begin
			last_vec <= io_wdata;
		end
	end
	// ==========================================================
	// Remote acknowledge steps
	sequence s_remote_match;
		!remote_iack_n && remote_iack_level >= OUT_LEVEL_MIN && irq_n_oe[remote_iack_level];
	endsequence
	sequence s_remote_done;
		dtack_n_oe ##1 $rose(remote_iack_n);
	endsequence
	AST_SOFT_NMI: assert property (iack_n && io_wr && io_addr == OFS_SOFT_NMI |-> ##[1:3] host_channel_check)
		else $error("soft NMI write did not raise channel check");
	AST_ACK_WAIT: assert property (!iack_n && dtack_n_i |=> !io_ready)
		else $error("ready before backplane DTACK");
	AST_ACK_LEVEL: assert property ($fell(iack_n) |-> iack_level != 3'h0 && !irq_n_i[iack_level])
		else $error("acknowledge started on an idle level");
	AST_ACK_DATA: assert property (!iack_n && $fell(dtack_n_i) |=> io_ready && io_rdata == $past(vme_data_i))
		else $error("acknowledge read lost the vector");
	AST_OUT_RAISE: assert property ($rose(|irq_n_oe) |-> $past(wr_out))
		else $error("outgoing line rose without a vector write");
	AST_OUT_ONEHOT: assert property (|irq_n_oe |-> $onehot(irq_n_oe) && irq_n_oe[2:1] == 2'h0)
		else $error("outgoing request on a wrong line");
	AST_OUT_ANSWER: assert property (s_remote_match |=> vme_data_oe && dtack_n_oe && vme_data_o == last_vec)
		else $error("remote acknowledge not answered with the vector");
	AST_OUT_RELEASE: assert property (s_remote_done |=> !dtack_n_oe && !vme_data_oe && irq_n_oe == 7'h00)
		else $error("outgoing request not released");
	AST_HOST_LINE: assert property ((host_irq5 | host_irq11 | host_irq12) |-> $onehot({host_irq5, host_irq11, host_irq12})
		&& (host_irq5 ? host_level_strap == STRAP_LEVEL5 : host_irq11 ? host_level_strap == STRAP_LEVEL11
		: host_level_strap == STRAP_LEVEL12))
		else $error("host request on a line the strap did not pick");
endmodule
bind backplane_interrupt_unit backplane_interrupt_unit_monitor i_backplane_interrupt_unit_monitor (.*);

// ==== bench/backplane_interrupt_unit_tb_top.sv ====
// Self-checking bench: register tasks on the local bus, one task a scenario.
// Assumes the partner model and the bound checker.
`timescale 1ns/1ps
module backplane_interrupt_unit_tb_top
	import backplane_irq_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic io_rd = 1'b0;
	logic io_wr = 1'b0;
	logic hen = 1'b0;
	logic power_fail_n = 1'b1;
	logic system_fail_n = 1'b1;
	logic bus_error_n = 1'b1;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00;
	logic [7:1] req = 7'h00;
	logic [1:0] host_level_strap = STRAP_LEVEL12;
	logic [7:0] io_rdata, vme_data_i, vme_data_o, got_vec;
	logic io_ready, host_channel_check, host_irq5, host_irq11, host_irq12, iack_n;
	logic remote_iack_n, vme_data_oe, dtack_n_i, dtack_n_oe;
	logic [7:1] irq_n_i, irq_n_oe;
	logic [2:0] iack_level, remote_iack_level;
	int err_total = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	backplane_interrupt_unit i_backplane_interrupt_unit (.clk(clk), .rst_n(rst_n),
		.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_ready(io_ready), .host_level_strap(host_level_strap), .host_channel_check(host_channel_check),
		.host_irq5(host_irq5), .host_irq11(host_irq11), .host_irq12(host_irq12),
		.power_fail_n(power_fail_n), .system_fail_n(system_fail_n), .bus_error_n(bus_error_n),
		.irq_n_i(irq_n_i), .irq_n_o(), .irq_n_oe(irq_n_oe), .iack_n(iack_n), .iack_level(iack_level),
		.remote_iack_n(remote_iack_n), .remote_iack_level(remote_iack_level), .vme_data_i(vme_data_i),
		.vme_data_o(vme_data_o), .vme_data_oe(vme_data_oe), .dtack_n_i(dtack_n_i), .dtack_n_o(),
		.dtack_n_oe(dtack_n_oe));
	backplane_partner #(.DLY(3)) i_backplane_partner (.clk(clk), .rst_n(rst_n), .hen(hen), .req(req),
		.hlvl(3'h5), .irq_n_oe(irq_n_oe), .iack_n(iack_n), .vme_data_oe(vme_data_oe),
		.dtack_n_oe(dtack_n_oe), .iack_level(iack_level), .vme_data_o(vme_data_o), .irq_n_i(irq_n_i),
		.vme_data_i(vme_data_i), .got_vec(got_vec), .dtack_n_i(dtack_n_i),
		.remote_iack_n(remote_iack_n), .remote_iack_level(remote_iack_level));
	// ==========================================================
	// Verdict, comparison and bus tasks
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait; a hang counts as a mismatch
	task automatic wait_ready;
		int i;
		i = 0;
		while (io_ready !== 1'b1 && i < 100) begin
			@(negedge clk);
			i++;
		end
		if (io_ready !== 1'b1) begin
			err_total++;
			end_sim();
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		@(negedge clk);
		io_wr = 1'b0;
		io_rd = 1'b0;
		wait_ready();
		q = io_rdata;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_soft;
		logic [7:0] v;
		acc(1'b1, OFS_SOFT_NMI, 8'h3C, v);
		chk({7'h0, host_channel_check}, 8'h01);
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({7'h0, v[BIT_SOFT]}, 8'h01);
		acc(1'b1, OFS_CLEAR_COND, 8'h20, v);
		acc(1'b1, OFS_CLEAR_COND, 8'h00, v);
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({6'h0, v[BIT_SOFT], host_channel_check}, 8'h00);
	endtask
	// Fail lines gate straight through, no latch; disabled source stays quiet
	task automatic t_fail;
		logic [7:0] v;
		acc(1'b1, OFS_GROUP_MASK, 8'h90, v);
		power_fail_n = 1'b0;
		#1 chk({7'h0, host_channel_check}, 8'h01);
		@(negedge clk);
		power_fail_n = 1'b1;
		#1 chk({7'h0, host_channel_check}, 8'h00);
		@(negedge clk);
		// Handler brackets its run with the status lamp, kept outside this unit
		system_fail_n = 1'b0;
		#1 chk({7'h0, host_channel_check}, 8'h01);
		acc(1'b1, OFS_GROUP_MASK, 8'h00, v);
		chk({7'h0, host_channel_check}, 8'h00);
		system_fail_n = 1'b1;
	endtask
	task automatic bus_error_condition_pulse;
		@(negedge clk);
		bus_error_n = 1'b0;
		@(negedge clk);
		bus_error_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_bus_error_condition;
		logic [7:0] v;
		acc(1'b1, OFS_GROUP_MASK, 8'h08, v);
		bus_error_condition_pulse();
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({6'h0, v[BIT_BUS_ERROR_CONDITION], host_channel_check}, 8'h03);
		acc(1'b1, OFS_CLEAR_COND, 8'h08, v);
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({6'h0, v[BIT_BUS_ERROR_CONDITION], host_channel_check}, 8'h00);
		bus_error_condition_pulse();
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({6'h0, v[BIT_BUS_ERROR_CONDITION], host_channel_check}, 8'h00);
		acc(1'b1, OFS_CLEAR_COND, 8'h00, v);
		acc(1'b1, OFS_GROUP_MASK, 8'h00, v);
	endtask
	task automatic t_out;
		logic [7:0] v;
		int i;
		hen = 1'b1;
		acc(1'b1, OFS_LEVEL_SELECT, 8'h05, v);
		acc(1'b1, OFS_OUT_VECTOR, 8'h6B, v);
		chk({1'b0, irq_n_oe}, 8'h10);
		i = 0;
		while (irq_n_oe !== 7'h00 && i < 100) begin
			@(negedge clk);
			i++;
		end
		if (irq_n_oe !== 7'h00) begin
			err_total++;
			end_sim();
		end
		chk(got_vec, 8'h6B);
		chk({1'b0, irq_n_oe}, 8'h00);
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({7'h0, v[BIT_DONE]}, 8'h01);
		acc(1'b1, OFS_GROUP_MASK, 8'h01, v);
		chk({5'h0, host_irq5, host_irq11, host_irq12}, 8'h01);
		// Other strap codes, changed only while no maskable request stands
		acc(1'b1, OFS_GROUP_MASK, 8'h00, v);
		host_level_strap = STRAP_LEVEL5;
		acc(1'b1, OFS_GROUP_MASK, 8'h01, v);
		chk({5'h0, host_irq5, host_irq11, host_irq12}, 8'h04);
		acc(1'b1, OFS_GROUP_MASK, 8'h00, v);
		host_level_strap = STRAP_LEVEL11;
		acc(1'b1, OFS_GROUP_MASK, 8'h01, v);
		chk({5'h0, host_irq5, host_irq11, host_irq12}, 8'h02);
		acc(1'b1, OFS_GROUP_MASK, 8'h00, v);
		host_level_strap = STRAP_LEVEL12;
		hen = 1'b0;
	endtask
	// IRQ1, IRQ3 enabled, IRQ5 masked, DONE still pending
	task automatic t_ack;
		logic [7:0] v;
		req = 7'h15;
		acc(1'b1, OFS_LEVEL_MASK, 8'h05, v);
		acc(1'b1, OFS_GROUP_MASK, 8'h05, v);
		acc(1'b1, OFS_DONE_VECTOR, 8'h5C, v);
		acc(1'b0, OFS_LINE_STATUS, 8'h00, v);
		chk(v, 8'h15);
		acc(1'b0, OFS_ACK_VECTOR, 8'h00, v);
		chk(v, 8'hA3);
		repeat (4) @(negedge clk);
		acc(1'b0, OFS_ACK_VECTOR, 8'h00, v);
		chk(v, 8'hA1);
		repeat (4) @(negedge clk);
		acc(1'b0, OFS_ACK_VECTOR, 8'h00, v);
		chk(v, 8'h5C);
		acc(1'b0, OFS_LINE_STATUS, 8'h00, v);
		chk(v, 8'h10);
		req = 7'h00;
		acc(1'b1, OFS_CLEAR_COND, 8'h01, v);
		acc(1'b0, OFS_GROUP_STATUS, 8'h00, v);
		chk({6'h0, v[BIT_DONE], host_irq12}, 8'h00);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_soft();
		t_fail();
		t_bus_error_condition();
		t_out();
		t_ack();
		end_sim();
	end
endmodule

// ==== bench/backplane_partner.sv ====
// Far side model: interrupters answering the unit's acknowledge cycle and a
// remote handler acknowledging its outgoing request. Bench picks the lines.
`timescale 1ns/1ps
module backplane_partner
	import backplane_irq_pkg::*;
#(
	parameter int DLY = 3
)
(
	// Clock, reset and bench controls
	input wire logic clk, rst_n, hen,
	input wire logic [7:1] req,
	input wire logic [2:0] hlvl,
	// Unit drives
	input wire logic [7:1] irq_n_oe,
	input wire logic iack_n, vme_data_oe, dtack_n_oe,
	input wire logic [2:0] iack_level,
	input wire logic [7:0] vme_data_o,
	// Resolved backplane lines
	output logic [7:1] irq_n_i,
	output logic [7:0] vme_data_i, got_vec,
	output logic dtack_n_i, remote_iack_n,
	output logic [2:0] remote_iack_level
);
	logic [7:1] acked;
	logic ans;
	logic [3:0] ac, hc;
	logic [7:0] last;
	// Open-drain lines low when any party pulls; released data is inverted
	assign irq_n_i = ~((req & ~acked) | irq_n_oe);
	assign dtack_n_i = ~(ans | dtack_n_oe);
	assign vme_data_i = vme_data_oe ? vme_data_o : (ans ? {5'h14, iack_level} : ~last);
	assign remote_iack_level = remote_iack_n ? ~hlvl : hlvl;
	// Interrupter answers slowly; handler takes the byte at DTACK
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acked <= 7'h00;
			ans <= 1'b0;
			ac <= 4'h0;
			hc <= 4'h0;
			last <= 8'h00;
			got_vec <= 8'h00;
			remote_iack_n <= 1'b1;
		end else begin
			last <= vme_data_i;
			acked <= acked & req;
			if (iack_n) begin
				ans <= 1'b0;
				ac <= 4'h0;
			end else if (!ans) begin
				ac <= ac + 4'h1;
				if (ac == DLY[3:0]) begin
					ans <= 1'b1;
					acked[iack_level] <= 1'b1; // Line drops once acknowledged
				end
			end
			if (!remote_iack_n) begin
				if (!dtack_n_i) begin
					got_vec <= vme_data_i;
					remote_iack_n <= 1'b1;
				end
			end else if (hen && !irq_n_i[hlvl]) begin
				hc <= hc + 4'h1;
				if (hc == DLY[3:0]) begin
					remote_iack_n <= 1'b0;
					hc <= 4'h0;
				end
			end else begin
				hc <= 4'h0;
			end
		end
	end
endmodule

// ==== core/backplane_interrupt_unit.sv ====
// Backplane interrupt unit: NMI sources, maskable request forwarding,
// outgoing interrupter and acknowledge handling, all in one clock domain.
// Assumes backplane pins are already synchronous to clk and that the
// processor issues one I/O request at a time and waits for io_ready.
//
// What this block does
// [RULE_01] Any write to trigger register raises NMI
// [RULE_02] Software NMI flag visible in group status
// [RULE_03] Clear-condition bit set then clear drops flag
// [RULE_04] NMI reaches processor within three clocks
// [RULE_05] Enabled power-fail drives NMI as level
// [RULE_06] Software disables power-fail while still active
// [RULE_07] Enabled system-fail drives NMI as level
// [RULE_08] Handler toggles status lamp around its run; this block has no lamp, it is kept outside the unit
// [RULE_09] Every bus-error rising edge raises NMI; code raises it only with the mask bit set and the clear bit unset
// [RULE_10] Writing bus-error clear bit drops condition
// [RULE_11] DONE and requests share strapped host line
// [RULE_12] Acknowledge read runs cycle, returns vector
// [RULE_13] Processor waits until backplane DTACK arrives
// [RULE_14] Highest unmasked level served, seven highest
// [RULE_15] DONE vector when only DONE pending
// [RULE_16] Set clear bit masks DONE and bus-error
// [RULE_17] Software polls status then re-arms clear bit
// [RULE_18] Raw request lines readable regardless of mask
// [RULE_19] Masked request lines never acknowledged
// [RULE_20] Vector write asserts selected line three-seven
// [RULE_21] Remote acknowledge answered with last vector
// [RULE_22] Outgoing acknowledge sets DONE condition
// [RULE_23] Serious sources assert host channel check
// [RULE_24] Outgoing line released after acknowledge completes
`timescale 1ns/1ps

module backplane_interrupt_unit
	import backplane_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Local processor I/O bus
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_ready,
	// Host interrupt lines and strap
	input wire logic [1:0] host_level_strap,
	output logic host_channel_check,
	output logic host_irq5,
	output logic host_irq11,
	output logic host_irq12,
	// Backplane system condition lines, active low
	input wire logic power_fail_n,
	input wire logic system_fail_n,
	input wire logic bus_error_n,
	// Backplane request lines IRQ7..IRQ1, open drain
	input wire logic [7:1] irq_n_i,
	output logic [7:1] irq_n_o,
	output logic [7:1] irq_n_oe,
	// Acknowledge cycle run by this unit as handler
	output logic iack_n,
	output logic [2:0] iack_level,
	// Acknowledge cycle arriving from a remote handler
	input wire logic remote_iack_n,
	input wire logic [2:0] remote_iack_level,
	// Backplane data byte, two-way
	input wire logic [7:0] vme_data_i,
	output logic [7:0] vme_data_o,
	output logic vme_data_oe,
	// Backplane DTACK, open drain
	input wire logic dtack_n_i,
	output logic dtack_n_o,
	output logic dtack_n_oe
);

	// ==========================================================
	// Decoding helpers

	// Highest requesting level, 7 first; zero when none
	function automatic logic [2:0] top_level(input logic [7:1] req);
		logic [2:0] lvl;
		lvl = 3'h0;
		for (int i = 1; i <= 7; i++) begin
			if (req[i]) begin
				lvl = 3'(i);
			end
		end
		return lvl;
	endfunction

	// One-hot line for a level code; codes below three select nothing
	function automatic logic [7:1] level_line(input logic [2:0] code);
		logic [7:1] line;
		line = 7'h00;
		for (int i = 1; i <= 7; i++) begin
			if (code == 3'(i) && code >= OUT_LEVEL_MIN) begin
				line[i] = 1'b1;
			end
		end
		return line;
	endfunction

	// ==========================================================
	// State of the whole unit
	typedef struct packed {
		logic [6:0] level_mask;
		logic [7:0] group_source_mask;
		logic [7:0] condition_clear;
		logic [7:0] done_vector;
		logic [2:0] outgoing_level_code;
		logic [7:0] outgoing_vector;
		logic outgoing_pending;
		logic answering;
		logic software_nmi_flag;
		logic bus_error_condition;
		logic done_condition;
		logic bus_error_q;
		ack_state_t ack_state;
		logic [2:0] ack_level;
		logic [7:0] rdata;
		logic ready;
		logic [1:0] strap;
	} state_t;

	state_t s;
	state_t next_s;

	logic [7:1] irq_active;
	logic [7:1] irq_enabled;
	logic vme_pending;
	logic power_fail_nmi;
	logic system_fail_nmi;
	logic bus_error_rise;
	logic remote_match;
	logic [7:0] group_status;
	logic maskable_req;

	// ==========================================================
	// Combinational conditions
	assign irq_active = ~irq_n_i; // [RULE_18]
	assign irq_enabled = irq_active & s.level_mask; // [RULE_19]
	assign vme_pending = |irq_enabled;

	// Level sources pass straight through; no latch, so the NMI drops
	// as soon as the line or its enable goes away
	assign power_fail_nmi = ~power_fail_n & s.group_source_mask[BIT_POWER_FAIL_ENABLE]; // [RULE_05]
	assign system_fail_nmi = ~system_fail_n & s.group_source_mask[BIT_SYSTEM_FAIL_ENABLE]; // [RULE_07]
	// Edge of the pin going inactive again marks a finished bus error
	assign bus_error_rise = bus_error_n & ~s.bus_error_q; // [RULE_09]

	// Remote acknowledge addressed at our pending level
	assign remote_match = ~remote_iack_n && s.outgoing_pending
		&& remote_iack_level == s.outgoing_level_code
		&& s.outgoing_level_code >= OUT_LEVEL_MIN;

	// Group status image
	always_comb begin
		group_status = 8'h00;
		group_status[BIT_SYSTEM_FAIL_ENABLE] = ~system_fail_n;
		group_status[BIT_SOFT] = s.software_nmi_flag; // [RULE_02]
		group_status[BIT_POWER_FAIL_ENABLE] = ~power_fail_n;
		group_status[BIT_BUS_ERROR_CONDITION] = s.bus_error_condition;
		group_status[BIT_VME] = vme_pending;
		group_status[BIT_DONE] = s.done_condition;
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		next_s.ready = 1'b0;
		next_s.bus_error_q = bus_error_n;
		// Strap is static; sampled every cycle, never under reset
		next_s.strap = host_level_strap;

		// Clear-condition bits hold their conditions down while set
		if (s.condition_clear[BIT_SOFT]) begin
			next_s.software_nmi_flag = 1'b0; // [RULE_03]
		end
		if (s.condition_clear[BIT_BUS_ERROR_CONDITION]) begin
			next_s.bus_error_condition = 1'b0; // [RULE_10]
		end
		if (s.condition_clear[BIT_DONE]) begin
			next_s.done_condition = 1'b0;
		end

		// Hardware sets, gated off by the clear bits so a held clear wins
		if (bus_error_rise && !s.condition_clear[BIT_BUS_ERROR_CONDITION]) begin
			next_s.bus_error_condition = 1'b1; // [RULE_09] [RULE_16]
		end

		// Answer a remote acknowledge with the stored vector
		if (!s.answering && remote_match) begin
			next_s.answering = 1'b1; // [RULE_21]
		end else if (s.answering && remote_iack_n) begin
			next_s.answering = 1'b0;
			next_s.outgoing_pending = 1'b0; // [RULE_24]
			if (!s.condition_clear[BIT_DONE]) begin
				next_s.done_condition = 1'b1; // [RULE_22] [RULE_16]
			end
		end

		// Register writes take one cycle and answer with ready
		if (io_wr && s.ack_state == ACK_IDLE) begin
			next_s.ready = 1'b1;
			case (io_addr)
				OFS_LEVEL_MASK: begin
					next_s.level_mask = io_wdata[6:0];
				end
				OFS_GROUP_MASK: begin
					next_s.group_source_mask = io_wdata;
				end
				OFS_CLEAR_COND: begin
					next_s.condition_clear = io_wdata;
				end
				OFS_DONE_VECTOR: begin
					next_s.done_vector = io_wdata;
				end
				OFS_SOFT_NMI: begin
					next_s.software_nmi_flag = 1'b1; // [RULE_01]
				end
				OFS_LEVEL_SELECT: begin
					next_s.outgoing_level_code = io_wdata[2:0];
				end
				OFS_OUT_VECTOR: begin
					// Vector must not change under a running answer
					if (!s.answering) begin
						next_s.outgoing_vector = io_wdata;
						next_s.outgoing_pending = 1'b1; // [RULE_20]
					end
				end
				default: begin
				end
			endcase
		end

		// Reads and the handler side acknowledge cycle
		case (s.ack_state)
			ACK_IDLE: begin
				if (io_rd) begin
					next_s.ready = 1'b1;
					case (io_addr)
						OFS_LEVEL_MASK: next_s.rdata = {1'b0, s.level_mask};
						OFS_GROUP_MASK: next_s.rdata = s.group_source_mask;
						OFS_CLEAR_COND: next_s.rdata = s.condition_clear;
						OFS_DONE_VECTOR: next_s.rdata = s.done_vector;
						OFS_GROUP_STATUS: next_s.rdata = group_status;
						OFS_LEVEL_SELECT: begin
							next_s.rdata = {s.outgoing_pending, 4'h0, s.outgoing_level_code};
						end
						OFS_LINE_STATUS: next_s.rdata = {1'b0, irq_active}; // [RULE_18]
						OFS_ACK_VECTOR: begin
							if (vme_pending) begin
								// Backplane request beats DONE; wait for DTACK
								next_s.ready = 1'b0; // [RULE_13]
								next_s.ack_level = top_level(irq_enabled); // [RULE_14]
								next_s.ack_state = ACK_WAIT; // [RULE_12] [RULE_15]
							end else begin
								next_s.rdata = s.done_vector; // [RULE_15]
							end
						end
						default: next_s.rdata = 8'h00;
					endcase
				end
			end
			ACK_WAIT: begin
				// Processor stays in wait states until DTACK
				if (!dtack_n_i) begin
					next_s.rdata = vme_data_i; // [RULE_12]
					next_s.ready = 1'b1; // [RULE_13]
					next_s.ack_state = ACK_RELEASE;
				end
			end
			ACK_RELEASE: begin
				// Let the interrupter remove DTACK before going idle
				if (dtack_n_i) begin
					next_s.ack_state = ACK_IDLE;
				end
			end
			default: begin
				next_s.ack_state = ACK_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s.level_mask <= RST_LEVEL_MASK;
			s.group_source_mask <= RST_GROUP_MASK;
			s.condition_clear <= RST_CLEAR_COND;
			s.done_vector <= RST_VECTOR;
			s.outgoing_level_code <= RST_LEVEL_SEL;
			s.outgoing_vector <= RST_VECTOR;
			s.outgoing_pending <= 1'b0;
			s.answering <= 1'b0;
			s.software_nmi_flag <= 1'b0;
			s.bus_error_condition <= 1'b0;
			s.done_condition <= 1'b0;
			s.bus_error_q <= 1'b1;
			s.ack_state <= ACK_IDLE;
			s.ack_level <= 3'h0;
			s.rdata <= 8'h00;
			s.ready <= 1'b0;
			s.strap <= RST_STRAP;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Host-facing outputs
	assign io_rdata = s.rdata;
	assign io_ready = s.ready;

	// Flag is registered one edge after the write, well inside the limit
	assign host_channel_check = s.software_nmi_flag // [RULE_04] [RULE_23]
		| power_fail_nmi | system_fail_nmi
		| (s.bus_error_condition & s.group_source_mask[BIT_BUS_ERROR_CONDITION]);

	// DONE and enabled backplane requests share one strapped line
	assign maskable_req = (s.done_condition & s.group_source_mask[BIT_DONE])
		| (vme_pending & s.group_source_mask[BIT_VME]); // [RULE_11]
	assign host_irq5 = maskable_req && s.strap == STRAP_LEVEL5; // [RULE_11]
	assign host_irq11 = maskable_req && s.strap == STRAP_LEVEL11;
	assign host_irq12 = maskable_req && s.strap == STRAP_LEVEL12;

	// ==========================================================
	// Backplane-facing outputs
	assign irq_n_o = 7'h00; // Open drain only ever pulls low
	assign irq_n_oe = s.outgoing_pending ? level_line(s.outgoing_level_code) : 7'h00; // [RULE_20]
	assign iack_n = s.ack_state != ACK_WAIT;
	assign iack_level = s.ack_level;
	assign vme_data_o = s.outgoing_vector; // [RULE_21]
	assign vme_data_oe = s.answering;
	assign dtack_n_o = 1'b0;
	assign dtack_n_oe = s.answering;

endmodule

// ==== core/backplane_irq_pkg.sv ====
// Constants for the backplane interrupt unit: register offsets, bit positions,
// reset values, handshake states and timing figures.
// Assumes a 200 MHz processor-side clock and an 8-bit local I/O bus.
package backplane_irq_pkg;

	// ==========================================================
	// Register offsets on the local I/O bus
	localparam logic [15:0] OFS_LEVEL_MASK = 16'h0147;
	localparam logic [15:0] OFS_GROUP_MASK = 16'h0148;
	localparam logic [15:0] OFS_CLEAR_COND = 16'h0149;
	localparam logic [15:0] OFS_DONE_VECTOR = 16'h014B;
	localparam logic [15:0] OFS_GROUP_STATUS = 16'h014C; // Read side
	localparam logic [15:0] OFS_SOFT_NMI = 16'h014C; // Write side
	localparam logic [15:0] OFS_ACK_VECTOR = 16'h014D;
	localparam logic [15:0] OFS_LEVEL_SELECT = 16'h014E;
	localparam logic [15:0] OFS_LINE_STATUS = 16'h014F; // Read side
	localparam logic [15:0] OFS_OUT_VECTOR = 16'h014F; // Write side

	// ==========================================================
	// Bit positions in group mask, clear condition and group status
	localparam int BIT_DONE = 0;
	localparam int BIT_VME = 2;
	localparam int BIT_BUS_ERROR_CONDITION = 3;
	localparam int BIT_POWER_FAIL_ENABLE = 4;
	localparam int BIT_SOFT = 5;
	localparam int BIT_SYSTEM_FAIL_ENABLE = 7;
	localparam int BIT_PENDING_FLAG = 7;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_GROUP_MASK = 8'h00;
	localparam logic [7:0] RST_CLEAR_COND = 8'h00;
	localparam logic [6:0] RST_LEVEL_MASK = 7'h00;
	localparam logic [7:0] RST_VECTOR = 8'h00;
	localparam logic [2:0] RST_LEVEL_SEL = 3'h0;
	localparam logic [1:0] RST_STRAP = 2'h1; // Host level 11

	// Host maskable level strap codes
	localparam logic [1:0] STRAP_LEVEL5 = 2'h0;
	localparam logic [1:0] STRAP_LEVEL11 = 2'h1;
	localparam logic [1:0] STRAP_LEVEL12 = 2'h2;

	// Lowest outgoing level the interrupter may drive
	localparam logic [2:0] OUT_LEVEL_MIN = 3'h3;

	// ==========================================================
	// Timing: latest NMI after trigger write, beyond the instruction
	localparam int NMI_LATENCY_CLOCKS = 3;
	localparam int CLK_PERIOD_PS = 5000;

	// Acknowledge handshake states, Gray along idle -> wait -> release
	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_RELEASE = 2'b11
	} ack_state_t;

endpackage
